// ### pkg/ape_pkg.sv
// Constants, encodings and helpers shared by the accumulator and port execution block.
package ape_pkg;
   localparam int          NIB_W        = 4;
   localparam int          WORD_W       = 10;
   localparam int          PAGE_W       = 2;
   localparam int          ROM_AW       = 10;
   localparam int          NPORT        = 8;
   localparam int          FLD_CLS      = 6;
   localparam int          FLD_BANK     = 5;
   localparam int          FLD_FORM     = 4;
   localparam logic [3:0]  CLS_AND      = 4'hd;
   localparam logic [3:0]  CLS_OR       = 4'he;
   localparam logic [3:0]  CLS_XOR      = 4'ha;
   localparam logic [3:0]  CLS_MOVE     = 4'hf;
   localparam logic [3:0]  CLS_STORE    = 4'h2;
   localparam logic [3:0]  CLS_PAIR     = 4'h3;
   localparam logic [3:0]  CLS_SYS      = 4'h1;
   localparam logic [4:0]  ROM_TAIL     = 5'h10;
   localparam logic [5:0]  IMM_TAIL     = 6'h31;
   localparam logic [1:0]  PORT_MARK    = 2'h3;
   localparam logic [2:0]  PAIR_MARK    = 3'h3;
   localparam logic [9:0]  OP_INC       = 10'h293;
   localparam logic [9:0]  OP_RL        = 10'h3f3;
   localparam logic [9:0]  OP_RLZ       = 10'h3d3;
   localparam logic [9:0]  OP_ALL_ONES_CARRY_OP      = 10'h393;
   localparam logic [9:0]  OP_HALT      = 10'h051;
   localparam logic [9:0]  OP_STATUS_TEST_OP_IMM  = 10'h071;
   localparam logic [1:0]  LOP_AND      = 2'h0;
   localparam logic [1:0]  LOP_OR       = 2'h1;
   localparam logic [1:0]  LOP_XOR      = 2'h2;
   localparam logic [1:0]  REG_PAGE     = 2'h0;
   localparam logic [1:0]  REG_STAT     = 2'h1;
   localparam logic [3:0]  ACC_RST      = 4'h0;
   localparam logic [3:0]  ALL_ONES     = 4'hf;
   localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
   localparam logic [4:0]  PTR_LO_ADDR  = 5'h00;
   localparam logic [4:0]  PTR_HI_ADDR  = 5'h10;

   typedef enum logic {ST_RUN, ST_STANDBY} ape_state_type;

   // Maps a port index to {valid, slot}; only indices 0, 1, 3 and 4 exist.
   function automatic logic [2:0] port_slot(input logic [2:0] idx);
      logic [2:0] r;
      r = 3'h0;
      unique case (idx)
         3'h0: r = 3'h4;
         3'h1: r = 3'h5;
         3'h3: r = 3'h6;
         3'h4: r = 3'h7;
         default: r = 3'h0;
      endcase
      return r;
   endfunction
endpackage

// ### pkg/ape_core_if.sv
// Interface joining the execution core to its register file and logic unit.
`timescale 1ns/1ps
`default_nettype none
interface ape_core_if;
   logic [4:0] raddr;
   logic [3:0] rdata;
   logic [3:0] ptr_hi;
   logic [3:0] ptr_lo;
   logic       we;
   logic [4:0] waddr;
   logic [3:0] wdata;
   logic [1:0] lop;
   logic [3:0] la;
   logic [3:0] lb;
   logic [3:0] lres;
   logic       lcy;
   modport core (output raddr, we, waddr, wdata, lop, la, lb,
                 input rdata, ptr_hi, ptr_lo, lres, lcy);
   modport rf (input raddr, we, waddr, wdata, output rdata, ptr_hi, ptr_lo);
   modport lu (input lop, la, lb, output lres, lcy);
endinterface
`default_nettype wire

// ### core/ape_regfile.sv
// General register file: two banks of sixteen nibbles, one addressed read port, two fixed pointer taps and one write port.
`timescale 1ns/1ps
`default_nettype none
module ape_regfile (
   input wire logic  clk,
   input wire logic  rst_b,
   ape_core_if.rf    rf
);
   import ape_pkg::*;
   logic [3:0] mem_q [32];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 32; i++) begin
            mem_q[i] <= 4'h0;
         end
      end else if (rf.we) begin
         mem_q[rf.waddr] <= rf.wdata;
      end
   end

   assign rf.rdata  = mem_q[rf.raddr];
   assign rf.ptr_lo = mem_q[PTR_LO_ADDR];
   assign rf.ptr_hi = mem_q[PTR_HI_ADDR];
endmodule
`default_nettype wire

// ### core/ape_logic_unit.sv
// Nibble logic unit for AND, OR and XOR with their carry rules.
`timescale 1ns/1ps
`default_nettype none
module ape_logic_unit (
   ape_core_if.lu lu
);
   import ape_pkg::*;
   logic top_and;

   assign top_and = lu.la[3] & lu.lb[3];
   assign lu.lres = (lu.lop == LOP_OR)  ? (lu.la | lu.lb) :
                    (lu.lop == LOP_XOR) ? (lu.la ^ lu.lb) : (lu.la & lu.lb);
   // OR always clears carry; AND and XOR take the product of the old top bits.
   assign lu.lcy  = (lu.lop == LOP_OR) ? 1'b0 : top_and;
endmodule
`default_nettype wire

// ### core/ape_exec.sv
// Accumulator, port and register-transfer instruction execution for the 4-bit core.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ape_exec (
   input  wire logic                            clk,
   input  wire logic                            rst_b,
   input  wire logic                            instr_valid,
   input  wire logic [ape_pkg::WORD_W-1:0]      instr_word,
   input  wire logic [ape_pkg::WORD_W-1:0]      instr_ext,
   input  wire logic [ape_pkg::WORD_W-1:0]      rom_data,
   output logic      [ape_pkg::ROM_AW-1:0]      rom_addr_q,
   input  wire logic [ape_pkg::NPORT*4-1:0]     port_pin_in,
   output logic      [ape_pkg::NPORT*4-1:0]     port_out_q,
   input  wire logic [3:0]                      wake_in,
   input  wire logic [3:0]                      status_in,
   output logic      [3:0]                      acc_q,
   output logic                                 carry_q,
   output logic                                 flag_q,
   output logic                                 standby_q,
   output logic                                 int_reset_q,
   input  wire logic [1:0]                      reg_addr,
   input  wire logic [7:0]                      reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [7:0]                      reg_rdata_q
);
   import ape_pkg::*;

   ape_core_if cif ();

   ape_regfile u_rf (
      .clk   (clk),
      .rst_b (rst_b),
      .rf    (cif.rf)
   );

   ape_logic_unit u_lu (
      .lu (cif.lu)
   );

   ape_state_type             state_q;
   ape_state_type             state_d;
   logic [31:0]               pin_meta_q;
   logic [31:0]               pin_s_q;
   logic [3:0]                wake_meta_q;
   logic [3:0]                wake_s_q;
   logic [3:0]                stat_meta_q;
   logic [3:0]                stat_s_q;
   logic [3:0]                mask_q;
   logic [3:0]                mask_d;
   logic [PAGE_W-1:0]         page_q;
   logic [PAGE_W-1:0]         page_d;
   logic [3:0]                acc_d;
   logic                      carry_d;
   logic                      flag_d;
   logic                      irst_d;
   logic [31:0]               port_d;
   logic [7:0]                rdata_d;

   wire  [3:0] cls      = instr_word[WORD_W-1:FLD_CLS];
   wire        bank     = instr_word[FLD_BANK];
   wire  [2:0] slot_w   = port_slot(instr_word[2:0]);
   wire  [2:0] pidx     = {bank, slot_w[1:0]};
   wire  [2:0] hi_idx   = {1'b1, slot_w[1:0]};
   wire  [2:0] lo_idx   = {1'b0, slot_w[1:0]};
   wire        f_reg    = !instr_word[FLD_FORM];
   wire        f_port   = (instr_word[4:3] == PORT_MARK) && slot_w[2];
   wire        f_rom    = (instr_word[4:0] == ROM_TAIL);
   wire        f_imm    = (instr_word[5:0] == IMM_TAIL);
   wire        f_any    = f_reg | f_port | f_rom | f_imm;
   wire        exec     = instr_valid && (state_q == ST_RUN);
   wire        special  = (instr_word == OP_ALL_ONES_CARRY_OP);
   wire        lg_op    = f_any && !special &&
                          (cls == CLS_AND || cls == CLS_OR || cls == CLS_XOR);
   wire        mv_op    = (cls == CLS_MOVE) && f_any;
   wire        is_inc   = (instr_word == OP_INC);
   wire        is_rl    = (instr_word == OP_RL);
   wire        is_rlz   = (instr_word == OP_RLZ);
   wire        is_all_ones_carry_op  = special;
   wire        is_halt  = (instr_word == OP_HALT);
   wire        status_test_op_imm = (instr_word == OP_STATUS_TEST_OP_IMM);
   wire        status_test_op_reg = (cls == CLS_SYS) && f_reg && bank;
   wire        is_out   = (cls == CLS_STORE) && f_port;
   wire        is_pair  = (cls == CLS_PAIR) && (instr_word[5:3] == PAIR_MARK) && slot_w[2];
   wire  [3:0] port_val = pin_s_q[{pidx, 2'b00} +: 4];
   wire  [3:0] rom_nib  = instr_word[FLD_BANK] ? rom_data[3:0] : rom_data[7:4];
   wire  [3:0] operand  = f_reg  ? cif.rdata :
                          f_port ? port_val  :
                          f_rom  ? rom_nib   : instr_ext[3:0];
   wire  [3:0] acc_inc  = acc_q + 4'h1;
   wire  [4:0] rot_w    = {acc_q[3], acc_q[2:0], acc_q[3]};
   wire  [3:0] status_test_op_sel = status_test_op_reg ? cif.rdata : instr_ext[3:0];
   wire        status_test_op_hit = |(status_test_op_sel & stat_s_q);
   wire        release_w = |(mask_q & wake_s_q);
   wire        cy3      = acc_q[3] & operand[3];
   wire  [3:0] ptr_lo_d = (cif.we && cif.waddr == PTR_LO_ADDR) ? acc_q : cif.ptr_lo;
   wire  [3:0] ptr_hi_d = (cif.we && cif.waddr == PTR_HI_ADDR) ? acc_q : cif.ptr_hi;

   // Register file and logic unit hookup; STATUS_TEST_OP always reads bank 0.
   assign cif.raddr = {bank & !status_test_op_reg, instr_word[3:0]};
   assign cif.we    = exec && (cls == CLS_STORE) && f_reg;
   assign cif.waddr = {bank, instr_word[3:0]};
   assign cif.wdata = acc_q;
   assign cif.lop   = (cls == CLS_OR) ? LOP_OR : (cls == CLS_XOR) ? LOP_XOR : LOP_AND;
   assign cif.la    = acc_q;
   assign cif.lb    = operand;
   assign page_d    = (reg_wr && reg_addr == REG_PAGE) ? reg_wdata[PAGE_W-1:0] : page_q;
   assign rdata_d   = !reg_rd ? 8'h00 :
                      (reg_addr == REG_PAGE) ? {6'h00, page_q} :
                      (reg_addr == REG_STAT) ? {1'b0, standby_q, flag_q, carry_q, acc_q} : 8'h00;

   always_comb begin
      state_d = state_q;
      mask_d  = mask_q;
      acc_d   = acc_q;
      carry_d = carry_q;
      flag_d  = flag_q;
      irst_d  = 1'b0;
      port_d  = port_out_q;
      unique case (state_q)
         ST_STANDBY: begin
            if (release_w) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!instr_valid) begin
               state_d = ST_RUN;
            end else if (lg_op) begin
               acc_d   = cif.lres;
               carry_d = cif.lcy;
            end else if (mv_op) begin
               acc_d   = operand;
               carry_d = 1'b0;
            end else if (is_inc) begin
               acc_d   = acc_inc;
               carry_d = (acc_inc == 4'h0);
            end else if (is_rlz && acc_q == 4'h0) begin
               acc_d   = ACC_RST;
               carry_d = 1'b0;
               irst_d  = 1'b1;
            end else if (is_rl || is_rlz) begin
               acc_d   = rot_w[3:0];
               carry_d = rot_w[4];
            end else if (is_all_ones_carry_op) begin
               carry_d = (acc_q == ALL_ONES);
            end else if (is_halt) begin
               state_d = ST_STANDBY;
               mask_d  = instr_ext[3:0];
            end else if (status_test_op_imm || status_test_op_reg) begin
               flag_d = status_test_op_hit;
            end else if (is_out) begin
               port_d[{pidx, 2'b00} +: 4] = acc_q;
            end else if (is_pair) begin
               port_d[{hi_idx, 2'b00} +: 4] = instr_ext[8:5];
               port_d[{lo_idx, 2'b00} +: 4] = instr_ext[3:0];
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_q  <= 32'h0;
         pin_s_q     <= 32'h0;
         wake_meta_q <= 4'h0;
         wake_s_q    <= 4'h0;
         stat_meta_q <= 4'h0;
         stat_s_q    <= 4'h0;
      end else begin
         pin_meta_q  <= port_pin_in;
         pin_s_q     <= pin_meta_q;
         wake_meta_q <= wake_in;
         wake_s_q    <= wake_meta_q;
         stat_meta_q <= status_in;
         stat_s_q    <= stat_meta_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q     <= ST_RUN;
         standby_q   <= 1'b0;
         mask_q      <= 4'h0;
         acc_q       <= ACC_RST;
         carry_q     <= 1'b0;
         flag_q      <= 1'b0;
         int_reset_q <= 1'b0;
         port_out_q  <= 32'h0;
         page_q      <= PAGE_RST;
         rom_addr_q  <= 10'h000;
         reg_rdata_q <= 8'h00;
      end else begin
         state_q     <= state_d;
         standby_q   <= (state_d == ST_STANDBY);
         mask_q      <= mask_d;
         acc_q       <= acc_d;
         carry_q     <= carry_d;
         flag_q      <= flag_d;
         int_reset_q <= irst_d;
         port_out_q  <= port_d;
         page_q      <= page_d;
         rom_addr_q  <= {page_d, ptr_hi_d, ptr_lo_d};
         reg_rdata_q <= rdata_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_and_carry_rule: assert property (exec && lg_op && cls == CLS_AND |=> carry_q == $past(cy3))
      else $error("AND carry wrong");
   a_rom_nibble_pick: assert property (exec && lg_op && f_rom && cls == CLS_OR
      |=> acc_q == ($past(acc_q) | $past(rom_nib)))
      else $error("ROM nibble operand wrong");
   a_or_carry_clear: assert property (exec && lg_op && cls == CLS_OR |=> !carry_q)
      else $error("OR left carry set");
   a_xor_result_carry: assert property (exec && lg_op && cls == CLS_XOR
      |=> acc_q == ($past(acc_q) ^ $past(operand)) && carry_q == $past(cy3))
      else $error("XOR result or carry wrong");
   a_inc_wrap_carry: assert property (exec && is_inc && acc_q == 4'hf |=> acc_q == 4'h0 && carry_q)
      else $error("increment wrap wrong");
   a_rotate_left_bits: assert property (exec && is_rl |=> {carry_q, acc_q} == $past(rot_w))
      else $error("rotate wrong");
   a_zero_rotate_reset: assert property (exec && is_rlz && acc_q == 4'h0
      |=> int_reset_q ##1 !int_reset_q)
      else $error("zero rotate did not pulse reset");
   a_port_in_load: assert property (exec && mv_op && f_port
      |=> acc_q == $past(port_val) && !carry_q)
      else $error("port input load wrong");
   a_port_out_latch: assert property (exec && is_out
      |=> port_out_q[{$past(pidx), 2'b00} +: 4] == $past(acc_q))
      else $error("port latch not written");
   a_pair_out_split: assert property (exec && is_pair
      |=> port_out_q[{$past(hi_idx), 2'b00} +: 4] == $past(instr_ext[8:5]))
      else $error("paired output upper nibble wrong");
   a_rom_addr_track: assert property (##1 rom_addr_q == {page_q, cif.ptr_hi, cif.ptr_lo})
      else $error("ROM address out of step");
   a_standby_hold: assert property (standby_q && !release_w |=> standby_q && $stable(acc_q))
      else $error("standby not held");
   a_status_flag_set: assert property (exec && (status_test_op_imm || status_test_op_reg) |=> flag_q == $past(status_test_op_hit))
      else $error("status flag wrong");
   a_pair_low_nibble: assert property (exec && is_pair
      |=> port_out_q[{$past(lo_idx), 2'b00} +: 4] == $past(instr_ext[3:0]))
      else $error("paired output lower nibble wrong");
   a_reg_move_clear: assert property (exec && mv_op && f_reg
      |=> acc_q == $past(cif.rdata) && !carry_q)
      else $error("register move wrong");
   a_rom_load_high: assert property (exec && mv_op && f_rom && !instr_word[FLD_BANK]
      |=> acc_q == $past(rom_data[7:4]) && !carry_q)
      else $error("high ROM load wrong");
   a_imm_and_carry: assert property (exec && lg_op && f_imm && cls == CLS_AND
      |=> acc_q == ($past(acc_q) & $past(instr_ext[3:0])) && carry_q == ($past(acc_q[3]) & $past(instr_ext[3])))
      else $error("immediate AND wrong");
   a_port_and_result: assert property (exec && lg_op && f_port && cls == CLS_AND
      |=> acc_q == ($past(acc_q) & $past(port_val)))
      else $error("port AND wrong");
   a_port_or_clear: assert property (exec && lg_op && f_port && cls == CLS_OR
      |=> acc_q == ($past(acc_q) | $past(port_val)) && !carry_q)
      else $error("port OR wrong");
   a_port_xor_carry: assert property (exec && lg_op && f_port && cls == CLS_XOR
      |=> carry_q == ($past(acc_q[3]) & $past(port_val[3])))
      else $error("port XOR carry wrong");
   a_port_latch_hold: assert property (!(exec && (is_out || is_pair))
      |=> $stable(port_out_q))
      else $error("port latch changed unasked");
   a_inc_plain_step: assert property (exec && is_inc && acc_q != 4'hf
      |=> acc_q == $past(acc_q) + 4'h1 && !carry_q)
      else $error("increment step wrong");
   a_rlz_plain_rotate: assert property (exec && is_rlz && acc_q != 4'h0
      |=> {carry_q, acc_q} == $past(rot_w))
      else $error("nonzero conditional rotate wrong");
   a_standby_entry: assert property (exec && is_halt
      |=> standby_q)
      else $error("standby not entered");

   c_zero_rotate: cover property (exec && is_rlz && acc_q == 4'h0);
   c_pair_output: cover property (exec && is_pair);
   c_standby_release: cover property (standby_q ##1 !standby_q);
   c_status_reg: cover property (exec && status_test_op_reg);
   c_port_output: cover property (exec && is_out);
endmodule
`default_nettype wire

// ### dv/ape_rom_model.sv
// Program memory model that answers the execution block's indirect reads.
`timescale 1ns/1ps
`default_nettype none
module ape_rom_model (
   input  wire logic [ape_pkg::ROM_AW-1:0] rom_addr,
   output logic      [ape_pkg::ROM_AW-1:0] rom_data
);
   import ape_pkg::*;
   // The page bits are folded into the low byte, so a wrong page bit changes the nibble that is read.
   assign rom_data = rom_addr ^ {2'h0, {4{rom_addr[9:8]}}};
endmodule
`default_nettype wire

// ### dv/test_accumulator_port_instruction_exec.sv
// Self-checking bench for the accumulator, port and transfer execution block.
`timescale 1ns/1ps
`default_nettype none
module test_accumulator_port_instruction_exec;
   import ape_pkg::*;
   logic        clk;
   logic        rst_b;
   logic        instr_valid;
   logic [9:0]  instr_word;
   logic [9:0]  instr_ext;
   logic [9:0]  rom_data;
   logic [9:0]  rom_addr_q;
   logic [9:0]  w;
   logic [31:0] port_pin_in;
   logic [31:0] port_out_q;
   logic [31:0] po;
   logic [31:0] pv;
   logic [3:0]  wake_in;
   logic [3:0]  status_in;
   logic [3:0]  acc_q;
   logic [3:0]  hi;
   logic [3:0]  lo;
   logic [3:0]  n4;
   logic        carry_q;
   logic        flag_q;
   logic        standby_q;
   logic        int_reset_q;
   logic [1:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata_q;
   logic [7:0]  d;
   logic [5:0]  rf;
   int          num_errors;
   int          total_checks;
   logic [3:0]  cl [3] = '{CLS_AND, CLS_OR, CLS_XOR};
   logic [3:0]  av [3] = '{4'hc, 4'hf, 4'h8};
   logic [3:0]  bv [3] = '{4'ha, 4'h6, 4'h8};
   logic [2:0]  id [4] = '{3'h0, 3'h1, 3'h3, 3'h4};

   ape_exec dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ext(instr_ext), .rom_data(rom_data), .rom_addr_q(rom_addr_q), .port_pin_in(port_pin_in),
      .port_out_q(port_out_q), .wake_in(wake_in), .status_in(status_in), .acc_q(acc_q), .carry_q(carry_q),
      .flag_q(flag_q), .standby_q(standby_q), .int_reset_q(int_reset_q), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
   ape_rom_model rom (.rom_addr(rom_addr_q), .rom_data(rom_data));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic op(input logic [9:0] wd, input logic [9:0] ex);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word  <= wd;
      instr_ext   <= ex;
   endtask
   task automatic idle();
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
   endtask
   // One instruction, then the accumulator and carry are compared.
   task automatic x1(input logic [9:0] wd, input logic [9:0] ex, input logic [4:0] e);
      op(wd, ex);
      idle();
      chk({acc_q, carry_q}, e);
   endtask
   task automatic ld(input logic [3:0] a);
      x1({CLS_MOVE, IMM_TAIL}, {6'h0, a}, {a, 1'b0});
   endtask
   // Loads a value and sets carry when the value is all ones.
   task automatic prep(input logic [3:0] a);
      ld(a);
      x1(OP_ALL_ONES_CARRY_OP, 10'h0, {a, a == 4'hf});
   endtask
   task automatic st(input logic [5:0] f, input logic [3:0] v);
      ld(v);
      op({CLS_STORE, f}, 10'h0);
      idle();
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_q, v);
   endtask
   function automatic logic [4:0] lx(input logic [3:0] c, input logic [3:0] a, input logic [3:0] b);
      if (c == CLS_AND) return {a & b, a[3] & b[3]};
      if (c == CLS_OR) return {a | b, 1'b0};
      return {a ^ b, a[3] & b[3]};
   endfunction
   task automatic test_done();
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      num_errors = 0;
      total_checks = 0;
      rst_b = 1'b0;
      {instr_valid, instr_word, instr_ext, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      {port_pin_in, wake_in, status_in, po} = '0;
      pv = 32'h8c5a_93e7;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      chk({acc_q, carry_q, flag_q, standby_q, int_reset_q, rom_addr_q, port_out_q}, 40'h0);
      rd(2'h1, 8'h00);
      wr(2'h3, 8'hff);
      rd(2'h3, 8'h00);
      rd(2'h0, 8'h00);
      foreach (av[j]) begin
         rf = {j[0], 1'b0, 4'(3 + j * 6)};
         st(rf, bv[j]);
         prep(4'hf);
         x1({CLS_MOVE, rf}, 10'h0, {bv[j], 1'b0});
         foreach (cl[i]) begin
            prep(av[j]);
            x1({cl[i], rf}, 10'h0, lx(cl[i], av[j], bv[j]));
            prep(av[j]);
            x1({cl[i], IMM_TAIL}, {6'h0, bv[j]}, lx(cl[i], av[j], bv[j]));
         end
      end
      for (int k = 0; k < 4; k++) begin
         hi = 4'(k * 5 + 2);
         lo = 4'(k * 3 + 1);
         wr(2'h0, 8'(k));
         rd(2'h0, 8'(k));
         st(6'h20, hi);
         st(6'h00, lo);
         @(posedge clk);
         #1;
         w = {k[1:0], hi, lo} ^ {2'h0, {4{k[1:0]}}};
         chk(rom_addr_q, {k[1:0], hi, lo});
         for (int l = 0; l < 2; l++) begin
            n4 = l[0] ? w[3:0] : w[7:4];
            prep(4'hf);
            x1({CLS_MOVE, l[0], ROM_TAIL}, 10'h0, {n4, 1'b0});
            foreach (cl[i]) begin
               prep(4'hb);
               x1({cl[i], l[0], ROM_TAIL}, 10'h0, lx(cl[i], 4'hb, n4));
            end
         end
      end
      @(posedge clk);
      port_pin_in <= pv;
      repeat (3) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         rf = {k[2], 2'b11, id[k[1:0]]};
         n4 = pv[4 * k +: 4];
         prep(4'hf);
         x1({CLS_MOVE, rf}, 10'h0, {n4, 1'b0});
         prep(k[0] ? 4'hf : 4'h9);
         x1({cl[k % 3], rf}, 10'h0, lx(cl[k % 3], k[0] ? 4'hf : 4'h9, n4));
         st(rf, 4'(k + 6));
         po[4 * k +: 4] = 4'(k + 6);
         chk(port_out_q, po);
      end
      st({1'b0, 2'b11, 3'h2}, 4'h3);
      chk(port_out_q, po);
      x1({CLS_MOVE, 1'b1, 2'b11, 3'h5}, 10'h0, {4'h3, 1'b0});
      for (int k = 0; k < 4; k++) begin
         d = 8'(k * 77 + 29);
         op({CLS_PAIR, 3'b011, id[k]}, {1'b0, d[7:4], 1'b0, d[3:0]});
         idle();
         po[4 * k +: 4] = d[3:0];
         po[4 * k + 16 +: 4] = d[7:4];
         chk(port_out_q, po);
      end
      op({CLS_MOVE, IMM_TAIL}, 10'h6);
      op(OP_INC, 10'h0);
      op(OP_RL, 10'h0);
      idle();
      chk({acc_q, carry_q}, {4'he, 1'b0});
      ld(4'he);
      x1(OP_INC, 10'h0, {4'hf, 1'b0});
      x1(OP_INC, 10'h0, {4'h0, 1'b1});
      ld(4'h9);
      x1(OP_RL, 10'h0, {4'h3, 1'b1});
      x1(OP_RL, 10'h0, {4'h6, 1'b0});
      ld(4'hc);
      x1(OP_RLZ, 10'h0, {4'h9, 1'b1});
      chk(int_reset_q, 1'b0);
      ld(4'h0);
      op(OP_RLZ, 10'h0);
      idle();
      chk({int_reset_q, acc_q, carry_q, port_out_q}, {1'b1, 5'h0, po});
      @(posedge clk);
      #1;
      chk(int_reset_q, 1'b0);
      @(posedge clk);
      status_in <= 4'h5;
      wake_in   <= 4'h1;
      repeat (3) @(posedge clk);
      op(OP_STATUS_TEST_OP_IMM, 10'h2);
      idle();
      chk(flag_q, 1'b0);
      op(OP_STATUS_TEST_OP_IMM, 10'h4);
      idle();
      chk(flag_q, 1'b1);
      op(OP_HALT, 10'h2);
      idle();
      chk(standby_q, 1'b1);
      x1(OP_INC, 10'h0, 5'h00);
      rd(2'h1, 8'h60);
      @(posedge clk);
      wake_in <= 4'h2;
      for (int n = 0; n < 8 && standby_q !== 1'b0; n++) begin
         @(posedge clk);
         #1;
      end
      chk(standby_q, 1'b0);
      x1(OP_INC, 10'h0, {4'h1, 1'b0});
      st(6'h07, 4'ha);
      op({CLS_SYS, 2'b10, 4'h7}, 10'h0);
      idle();
      chk(flag_q, 1'b0);
      st(6'h07, 4'h4);
      op({CLS_SYS, 2'b10, 4'h7}, 10'h0);
      idle();
      chk(flag_q, 1'b1);
      test_done();
   end
endmodule
`default_nettype wire
